// ==== rtl/aotst_pkg.sv ====
// shared constants and helpers for the always-on timestamp timer
package aotst_pkg;
   // counter and channel geometry
   localparam int CNT_W    = 64;
   localparam int TO_W     = 32;
   localparam int NUM_CH   = 12;
   localparam int CH_IDX_W = 4;
   localparam int DIV_W    = 2;
   localparam int DCNT_W   = 2;
   localparam int STEP_W   = 16;

   // divider settings: tick period taken from the fast source
   localparam logic [DIV_W-1:0] DIV_26M  = 2'h0;
   localparam logic [DIV_W-1:0] DIV_13M  = 2'h1;
   localparam logic [DIV_W-1:0] DIV_6M5  = 2'h2;
   localparam logic [DIV_W-1:0] DIV_RST  = DIV_13M;

   // fast-source pulses per tick, minus one, per divider setting
   localparam logic [DCNT_W-1:0] DCNT_26M = 2'h0;
   localparam logic [DCNT_W-1:0] DCNT_13M = 2'h1;
   localparam logic [DCNT_W-1:0] DCNT_6M5 = 2'h3;

   // step per fast tick and per slow-clock tick (fast rate / 32768)
   localparam logic [STEP_W-1:0] STEP_ONE     = 16'h0001;
   localparam logic [STEP_W-1:0] STEP_32K_26M = 16'h0319;
   localparam logic [STEP_W-1:0] STEP_32K_13M = 16'h018D;
   localparam logic [STEP_W-1:0] STEP_32K_6M5 = 16'h00C6;

   // permission mask bit positions and reset values
   localparam int PERM_W      = 32;
   localparam int PBIT_CTL    = 0;
   localparam int PBIT_CH0    = 4;
   localparam logic [PERM_W-1:0] WMASK_RST = 32'hFFFF_FFF0;
   localparam logic [PERM_W-1:0] RMASK_RST = 32'hFFFF_FFFF;

   // permission register select
   localparam logic [1:0] PSEL_WMASK = 2'h0;
   localparam logic [1:0] PSEL_RMASK = 2'h1;
   localparam logic [1:0] PSEL_LOCK  = 2'h2;

   // clock source mux states, gray coded along the loop
   typedef enum logic [1:0] {
      SRC_FAST    = 2'b00,
      SRC_TO_SLOW = 2'b01,
      SRC_SLOW    = 2'b11,
      SRC_TO_FAST = 2'b10
   } aotst_src_t;

   // binary to gray for the exported count
   function automatic logic [CNT_W-1:0] bin2gray(input logic [CNT_W-1:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction
endpackage

// ==== rtl/aotst_ch_if.sv ====
// link between the counter core and one timeout channel
`timescale 1ns/10ps
interface aotst_ch_if;
   logic [aotst_pkg::CNT_W-1:0] cnt;
   logic                        load;
   logic [aotst_pkg::TO_W-1:0]  load_val;
   logic [aotst_pkg::TO_W-1:0]  remain;
   logic                        fired;

   modport core (output cnt, output load, output load_val,
                 input remain, input fired);
   modport chan (input cnt, input load, input load_val,
                 output remain, output fired);
endinterface

// ==== rtl/aotst_chan.sv ====
// one timeout channel: target, remaining count and sticky interrupt
`timescale 1ns/10ps
module aotst_chan (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // core link
   aotst_ch_if.chan  ch
);
   logic [aotst_pkg::CNT_W-1:0] target_r;
   logic                        armed_r;
   logic                        fired_r;
   logic [aotst_pkg::CNT_W-1:0] diff;
   logic                        due;

   // signed distance copes with counter wrap and multi-count steps
   assign diff      = target_r - ch.cnt;
   assign due       = armed_r && $signed(diff) <= 0;
   assign ch.remain = fired_r ? '0 : diff[aotst_pkg::TO_W-1:0];
   assign ch.fired  = fired_r;

   // a new write wins: it re-arms and drops the old interrupt
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         target_r <= '0;
         armed_r  <= 1'b0;
         fired_r  <= 1'b0;
      end else if (ch.load) begin
         target_r <= ch.cnt + {32'h0000_0000, ch.load_val};
         armed_r  <= 1'b1;
         fired_r  <= 1'b0;
      end else if (due) begin
         armed_r  <= 1'b0;
         fired_r  <= 1'b1;
      end
   end
endmodule

// ==== rtl/aotst_top.sv ====
// always-on 64-bit timestamp counter with timeout channels
`timescale 1ns/10ps
module aotst_top #(
   parameter int NUM_CH = aotst_pkg::NUM_CH
) (
   // clock and reset
   input  wire logic                            sys_clk,
   input  wire logic                            rst,
   // tick sources, one-cycle enables from the source clocks, and the level request for the 32k source
   input  wire logic                            tick_fast_en,
   input  wire logic                            tick_32k_en,
   input  wire logic                            use_32k_req,
   // divider control write
   input  wire logic                            ctl_wr_en,
   input  wire logic                            ctl_wr_secure,
   input  wire logic [aotst_pkg::DIV_W-1:0]     ctl_wr_div,
   // channel timeout write
   input  wire logic                            ch_wr_en,
   input  wire logic                            ch_wr_secure,
   input  wire logic [aotst_pkg::CH_IDX_W-1:0]  ch_wr_idx,
   input  wire logic [aotst_pkg::TO_W-1:0]      ch_wr_val,
   // channel timeout read
   input  wire logic                            rd_en,
   input  wire logic                            rd_secure,
   input  wire logic [aotst_pkg::CH_IDX_W-1:0]  rd_idx,
   output logic      [aotst_pkg::TO_W-1:0]      rd_data,
   output logic                                 rd_valid,
   output logic                                 rd_denied,
   // permission registers
   input  wire logic                            perm_wr_en,
   input  wire logic                            perm_wr_secure,
   input  wire logic [1:0]                      perm_wr_sel,
   input  wire logic [aotst_pkg::PERM_W-1:0]    perm_wr_data,
   output logic      [aotst_pkg::PERM_W-1:0]    nonsecure_write_perm_mask,
   output logic      [aotst_pkg::PERM_W-1:0]    nonsecure_read_perm_mask,
   output logic                                 perm_mask_lock,
   // status
   output logic      [aotst_pkg::DIV_W-1:0]     div_sel,
   output logic                                 on_32k,
   // exported timestamp and interrupts
   output logic      [aotst_pkg::CNT_W-1:0]     ts_gray,
   output logic      [NUM_CH-1:0]               timeout_irq
);
   localparam int CW = aotst_pkg::CNT_W;

   logic [CW-1:0]                     cnt_r;
   logic [CW-1:0]                     cnt_nxt;
   logic [CW-1:0]                     gray_r;
   logic [aotst_pkg::DIV_W-1:0]       div_r;
   logic [aotst_pkg::DCNT_W-1:0]      dcnt_r;
   logic [aotst_pkg::DCNT_W-1:0]      dcnt_max;
   aotst_pkg::aotst_src_t             src_r;
   aotst_pkg::aotst_src_t             src_nxt;
   logic                              on_32k_r;
   logic [aotst_pkg::PERM_W-1:0]      wmask_r;
   logic [aotst_pkg::PERM_W-1:0]      rmask_r;
   logic                              lock_r;
   logic [aotst_pkg::TO_W-1:0]        rd_data_r;
   logic                              rd_valid_r;
   logic                              rd_denied_r;
   logic [aotst_pkg::STEP_W-1:0]      step_slow;
   logic [aotst_pkg::STEP_W-1:0]      step;
   logic                              fast_mode;
   logic                              fast_tick;
   logic                              slow_tick;
   logic                              adv;
   logic                              ctl_ok;
   logic                              ch_wr_ok;
   logic                              rd_idx_ok;
   logic                              rd_ok;
   logic                              perm_ok;
   logic [NUM_CH-1:0]                 irq_vec;
   logic [aotst_pkg::TO_W-1:0]        remain_arr [NUM_CH];

   // divider length and slow-mode step follow the divider setting
   assign dcnt_max = (div_r == aotst_pkg::DIV_26M) ? aotst_pkg::DCNT_26M :
                     (div_r == aotst_pkg::DIV_6M5) ? aotst_pkg::DCNT_6M5 :
                                                     aotst_pkg::DCNT_13M;
   assign step_slow = (div_r == aotst_pkg::DIV_26M) ? aotst_pkg::STEP_32K_26M :
                      (div_r == aotst_pkg::DIV_6M5) ? aotst_pkg::STEP_32K_6M5 :
                                                aotst_pkg::STEP_32K_13M;

   // tick selection: at most one source counts in any state, none in SRC_TO_FAST
   assign fast_mode = (src_r == aotst_pkg::SRC_FAST) ||
                      (src_r == aotst_pkg::SRC_TO_SLOW);
   assign fast_tick = fast_mode && tick_fast_en && (dcnt_r == dcnt_max);
   assign slow_tick = (src_r == aotst_pkg::SRC_SLOW) && tick_32k_en;
   assign adv       = fast_tick || slow_tick;
   assign step      = slow_tick ? step_slow : aotst_pkg::STEP_ONE;
   // plain add wraps modulo 2^64 past the top value
   assign cnt_nxt   = adv ? cnt_r + {48'h0000_0000_0000, step} : cnt_r;

   // mux: leave fast only at a divider boundary, enter on a source edge
   always_comb begin
      src_nxt = src_r;
      case (src_r)
         aotst_pkg::SRC_FAST:
            if (use_32k_req) begin
               src_nxt = aotst_pkg::SRC_TO_SLOW;
            end
         aotst_pkg::SRC_TO_SLOW:
            if (!use_32k_req) begin
               src_nxt = aotst_pkg::SRC_FAST;
            end else if (fast_tick || dcnt_r == '0) begin
               src_nxt = aotst_pkg::SRC_SLOW;
            end
         aotst_pkg::SRC_SLOW:
            if (!use_32k_req) begin
               src_nxt = aotst_pkg::SRC_TO_FAST;
            end
         aotst_pkg::SRC_TO_FAST:
            if (use_32k_req) begin
               src_nxt = aotst_pkg::SRC_SLOW;
            end else if (tick_fast_en) begin
               src_nxt = aotst_pkg::SRC_FAST;
            end
         default:
            src_nxt = aotst_pkg::SRC_FAST;
      endcase
   end

   // access checks: secure passes for an in-range index, non-secure per mask bit; permission writes are secure only
   assign ctl_ok    = ctl_wr_en &&
                      (ctl_wr_secure || wmask_r[aotst_pkg::PBIT_CTL]);
   assign ch_wr_ok  = ch_wr_en && (ch_wr_idx < NUM_CH) &&
                      (ch_wr_secure ||
                       wmask_r[aotst_pkg::PBIT_CH0 + ch_wr_idx]);
   assign rd_idx_ok = rd_idx < NUM_CH;
   assign rd_ok     = rd_idx_ok &&
                      (rd_secure || rmask_r[aotst_pkg::PBIT_CH0 + rd_idx]);
   assign perm_ok   = perm_wr_en && perm_wr_secure;

   // counter, divider and mux state; the count halts only in SRC_TO_FAST, until the next fast pulse or a renewed use_32k_req
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_r  <= '0;
         gray_r <= '0;
         dcnt_r <= '0;
         src_r  <= aotst_pkg::SRC_FAST;
         on_32k_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         gray_r <= aotst_pkg::bin2gray(cnt_nxt);
         src_r  <= src_nxt;
         on_32k_r <= (src_nxt == aotst_pkg::SRC_SLOW);
         if (!fast_mode || fast_tick) begin
            dcnt_r <= '0;
         end else if (tick_fast_en) begin
            dcnt_r <= dcnt_r + 2'h1;
         end
      end
   end

   // divider setting, reset value gives the 13MHz tick
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_r <= aotst_pkg::DIV_RST;
      end else if (ctl_ok && ctl_wr_div <= aotst_pkg::DIV_6M5) begin
         div_r <= ctl_wr_div;
      end
   end

   // permission masks and lock; lock only sets, reset alone clears it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wmask_r <= aotst_pkg::WMASK_RST;
         rmask_r <= aotst_pkg::RMASK_RST;
         lock_r  <= 1'b0;
      end else if (perm_ok) begin
         if (perm_wr_sel == aotst_pkg::PSEL_WMASK && !lock_r) begin
            wmask_r <= perm_wr_data;
         end
         if (perm_wr_sel == aotst_pkg::PSEL_RMASK && !lock_r) begin
            rmask_r <= perm_wr_data;
         end
         if (perm_wr_sel == aotst_pkg::PSEL_LOCK && perm_wr_data[0]) begin
            lock_r  <= 1'b1;
         end
      end
   end

   // read port: one cycle after rd_en, denied reads return zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_data_r   <= '0;
         rd_valid_r  <= 1'b0;
         rd_denied_r <= 1'b0;
      end else begin
         rd_valid_r  <= rd_en;
         rd_denied_r <= rd_en && !rd_ok;
         rd_data_r   <= (rd_en && rd_ok) ? remain_arr[rd_idx] : '0;
      end
   end

   // the timeout channels, each on its own link
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      aotst_ch_if link ();
      assign link.cnt      = cnt_r;
      assign link.load     = ch_wr_ok &&
                             (ch_wr_idx == aotst_pkg::CH_IDX_W'(i));
      assign link.load_val = ch_wr_val;
      assign remain_arr[i] = link.remain;
      assign irq_vec[i]    = link.fired;
      aotst_chan u_chan (
         .sys_clk (sys_clk),
         .rst     (rst),
         .ch      (link.chan)
      );
   end

   // outputs straight from flip-flops
   assign ts_gray                   = gray_r;
   assign timeout_irq               = irq_vec;
   assign rd_data                   = rd_data_r;
   assign rd_valid                  = rd_valid_r;
   assign rd_denied                 = rd_denied_r;
   assign nonsecure_write_perm_mask = wmask_r;
   assign nonsecure_read_perm_mask  = rmask_r;
   assign perm_mask_lock            = lock_r;
   assign div_sel                   = div_r;
   assign on_32k                    = on_32k_r;
endmodule

// ==== sim/aotst_rx.sv ====
// receiver-side model: turns the exported gray count back into binary
`timescale 1ns/10ps
module aotst_rx (
   // gray count from the timer
   input  wire logic [aotst_pkg::CNT_W-1:0] ts_gray,
   // recovered binary count
   output logic      [aotst_pkg::CNT_W-1:0] cnt_bin
);
   // prefix xor from the top bit down; no flop, the sender registers gray
   always_comb begin
      cnt_bin[aotst_pkg::CNT_W-1] = ts_gray[aotst_pkg::CNT_W-1];
      for (int i = aotst_pkg::CNT_W-2; i >= 0; i--) begin
         cnt_bin[i] = cnt_bin[i+1] ^ ts_gray[i];
      end
   end
endmodule

// ==== sim/aotst_chk.sv ====
// concurrent checks on the timestamp timer top ports
`timescale 1ns/10ps
module aotst_chk #(
   parameter int NUM_CH = 12
) (
   // clock and reset
   input wire logic              sys_clk,
   input wire logic              rst,
   // control, channel and permission writes
   input wire logic              ctl_wr_en,
   input wire logic              ctl_wr_secure,
   input wire logic [1:0]        ctl_wr_div,
   input wire logic              ch_wr_en,
   input wire logic              ch_wr_secure,
   input wire logic [3:0]        ch_wr_idx,
   input wire logic [31:0]       ch_wr_val,
   input wire logic              perm_wr_en,
   input wire logic              perm_wr_secure,
   // reads
   input wire logic              rd_en,
   input wire logic [3:0]        rd_idx,
   input wire logic [31:0]       rd_data,
   input wire logic              rd_valid,
   input wire logic              rd_denied,
   // state seen outside
   input wire logic [31:0]       nonsecure_write_perm_mask,
   input wire logic [31:0]       nonsecure_read_perm_mask,
   input wire logic              perm_mask_lock,
   input wire logic [1:0]        div_sel,
   input wire logic              on_32k,
   input wire logic [63:0]       ts_gray,
   input wire logic [NUM_CH-1:0] timeout_irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // accepted write to channel 0, secure or allowed by its mask bit
   sequence s_wr0;
      ch_wr_en && ch_wr_idx == 4'h0 &&
      (ch_wr_secure || nonsecure_write_perm_mask[4]);
   endsequence
   sequence s_arm0_now;
      s_wr0 ##0 ch_wr_val == 32'h0000_0000 ##1 !ch_wr_en;
   endsequence
   AST_RST_VALS: assert property ($fell(rst) |-> div_sel == 2'h1 &&
      nonsecure_write_perm_mask == 32'hFFFF_FFF0 && !perm_mask_lock &&
      nonsecure_read_perm_mask == 32'hFFFF_FFFF) else $error("reset values");
   // fast mode steps by one, so gray moves one bit at a time
   AST_GRAY_STEP: assert property (!on_32k && !$past(on_32k) &&
      ts_gray != $past(ts_gray) |-> $onehot(ts_gray ^ $past(ts_gray)))
      else $error("gray count moved more than one bit");
   AST_DIV_TAKE: assert property (ctl_wr_en && ctl_wr_div != 2'h3 &&
      (ctl_wr_secure || nonsecure_write_perm_mask[0])
      |=> div_sel == $past(ctl_wr_div)) else $error("divider not taken");
   AST_DIV_REFUSE: assert property (ctl_wr_en && !ctl_wr_secure &&
      !nonsecure_write_perm_mask[0] |=> $stable(div_sel))
      else $error("refused divider write took effect");
   AST_PERM_NONSEC: assert property (perm_wr_en && !perm_wr_secure
      |=> $stable(nonsecure_write_perm_mask) && $stable(perm_mask_lock))
      else $error("non-secure permission write took effect");
   AST_LOCK_FREEZE: assert property (perm_mask_lock |=>
      $stable(nonsecure_write_perm_mask) && $stable(nonsecure_read_perm_mask))
      else $error("mask changed while locked");
   AST_LOCK_STICKY: assert property (perm_mask_lock |=> perm_mask_lock)
      else $error("lock cleared without reset");
   AST_IRQ_REARM: assert property (s_wr0 |=> !timeout_irq[0])
      else $error("rewrite did not clear channel 0 interrupt");
   AST_IRQ_HOLD: assert property (timeout_irq[0] && !ch_wr_en
      |=> timeout_irq[0]) else $error("interrupt dropped by itself");
   // zero delta: due one edge after the write, seen at the edge after that
   AST_FIRE_ZERO: assert property (s_arm0_now |=> timeout_irq[0])
      else $error("zero timeout did not fire");
   AST_RD_VALID: assert property (rd_valid == $past(rd_en))
      else $error("read answer not one cycle after request");
   AST_RD_DENY: assert property (rd_en && rd_idx >= NUM_CH |=>
      rd_denied && rd_data == 32'h0000_0000) else $error("bad index read");
endmodule
bind aotst_top aotst_chk #(.NUM_CH(NUM_CH)) u_chk (.sys_clk, .rst,
   .ctl_wr_en, .ctl_wr_secure, .ctl_wr_div, .ch_wr_en, .ch_wr_secure,
   .ch_wr_idx, .ch_wr_val, .perm_wr_en, .perm_wr_secure, .rd_en, .rd_idx,
   .rd_data, .rd_valid, .rd_denied, .nonsecure_write_perm_mask,
   .nonsecure_read_perm_mask, .perm_mask_lock, .div_sel, .on_32k,
   .ts_gray, .timeout_irq);

// ==== sim/testbench.sv ====
// self-checking bench for the always-on timestamp timer
`timescale 1ns/10ps
module testbench;
   logic        sys_clk = 1'b0, rst = 1'b1;
   int          fails = 0, checks = 0, cyc_n = 0;
   logic        tick_fast_en, tick_32k_en, use_32k_req, ctl_wr_en;
   logic        ctl_wr_secure, ch_wr_en, ch_wr_secure, rd_en, rd_secure;
   logic        perm_wr_en, perm_wr_secure, rd_valid, rd_denied;
   logic        perm_mask_lock, on_32k;
   logic [1:0]  ctl_wr_div, perm_wr_sel, div_sel, d;
   logic [3:0]  ch_wr_idx, rd_idx;
   logic [31:0] ch_wr_val, perm_wr_data, rd_data;
   logic [31:0] nonsecure_write_perm_mask, nonsecure_read_perm_mask;
   logic [63:0] ts_gray, cnt, c0;
   logic [15:0] st;
   logic [11:0] timeout_irq;
   aotst_top dut (.sys_clk, .rst, .tick_fast_en, .tick_32k_en,
      .use_32k_req, .ctl_wr_en, .ctl_wr_secure, .ctl_wr_div, .ch_wr_en,
      .ch_wr_secure, .ch_wr_idx, .ch_wr_val, .rd_en, .rd_secure, .rd_idx,
      .rd_data, .rd_valid, .rd_denied, .perm_wr_en, .perm_wr_secure,
      .perm_wr_sel, .perm_wr_data, .nonsecure_write_perm_mask,
      .nonsecure_read_perm_mask, .perm_mask_lock, .div_sel, .on_32k,
      .ts_gray, .timeout_irq);
   aotst_rx rx (.ts_gray(ts_gray), .cnt_bin(cnt));
   always #50 sys_clk = ~sys_clk;
   // watchdog, the run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 5000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // n edges, then settle at the falling edge before looking
   task automatic clk(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   // one-cycle source pulses, a cycle apart so no edge is written twice
   task automatic tick(input int n, input logic slow);
      repeat (n) begin
         @(posedge sys_clk);
         if (slow) tick_32k_en <= 1'b1;
         else tick_fast_en <= 1'b1;
         @(posedge sys_clk);
         tick_32k_en <= 1'b0;
         tick_fast_en <= 1'b0;
      end
      clk(1);
   endtask
   task automatic wr_ch(input logic [3:0] i, input logic [31:0] v,
                        input logic s);
      @(posedge sys_clk);
      {ch_wr_en, ch_wr_idx, ch_wr_val, ch_wr_secure} <= {1'b1, i, v, s};
      @(posedge sys_clk);
      ch_wr_en <= 1'b0;
      clk(0);
   endtask
   task automatic rd(input logic [3:0] i, input logic s,
                     input logic [31:0] exp, input logic den);
      @(posedge sys_clk);
      {rd_en, rd_idx, rd_secure} <= {1'b1, i, s};
      @(posedge sys_clk);
      rd_en <= 1'b0;
      clk(0);
      chk(rd_valid, 1'b1);
      chk(rd_denied, den);
      chk(rd_data, exp);
   endtask
   task automatic ctl(input logic [1:0] v, input logic s);
      @(posedge sys_clk);
      {ctl_wr_en, ctl_wr_div, ctl_wr_secure} <= {1'b1, v, s};
      @(posedge sys_clk);
      ctl_wr_en <= 1'b0;
      clk(1);
   endtask
   task automatic perm(input logic [1:0] sl, input logic [31:0] v,
                       input logic s);
      @(posedge sys_clk);
      {perm_wr_en, perm_wr_sel, perm_wr_data, perm_wr_secure} <=
         {1'b1, sl, v, s};
      @(posedge sys_clk);
      perm_wr_en <= 1'b0;
      clk(1);
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      {tick_fast_en, tick_32k_en, use_32k_req, ctl_wr_en, ctl_wr_secure} = 0;
      {ch_wr_en, ch_wr_secure, rd_en, rd_secure, perm_wr_en} = 0;
      {perm_wr_secure, ctl_wr_div, perm_wr_sel, ch_wr_idx, rd_idx} = 0;
      {ch_wr_val, perm_wr_data} = 0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      clk(0);
      chk(ts_gray, 64'h0);
      chk(nonsecure_write_perm_mask, 32'hFFFF_FFF0);
      chk(nonsecure_read_perm_mask, 32'hFFFF_FFFF);
      chk(div_sel, aotst_pkg::DIV_13M);
      $display("test reset done");
      ctl(aotst_pkg::DIV_26M, 1'b0);
      chk(div_sel, aotst_pkg::DIV_13M);
      ctl(2'h3, 1'b1);
      chk(div_sel, aotst_pkg::DIV_13M);
      // 13M first so the divider phase starts aligned for every setting
      for (int k = 0; k < 3; k++) begin
         d = (k == 0) ? 2'h1 : (k == 1) ? 2'h0 : 2'h2;
         ctl(d, 1'b1);
         c0 = cnt;
         tick(4, 1'b0);
         chk(cnt - c0, 64'h4 >> d);
      end
      $display("test divider done");
      @(posedge sys_clk);
      use_32k_req <= 1'b1;
      for (int n = 0; n < 8 && !on_32k; n++) tick(1, 1'b0);
      chk(on_32k, 1'b1);
      c0 = cnt;
      tick(2, 1'b0);
      chk(cnt - c0, 64'h0);
      for (int k = 0; k < 3; k++) begin
         d = k[1:0];
         st = (k == 0) ? aotst_pkg::STEP_32K_26M :
              (k == 1) ? aotst_pkg::STEP_32K_13M : aotst_pkg::STEP_32K_6M5;
         ctl(d, 1'b1);
         c0 = cnt;
         tick(1, 1'b1);
         chk(cnt - c0, {48'h0, st});
      end
      @(posedge sys_clk);
      use_32k_req <= 1'b0;
      clk(2);
      chk(on_32k, 1'b0);
      tick(1, 1'b0);
      ctl(aotst_pkg::DIV_26M, 1'b1);
      c0 = cnt;
      tick(3, 1'b0);
      chk(cnt - c0, 64'h3);
      $display("test slow source done");
      for (int k = 0; k < 12; k++) wr_ch(k[3:0], 32'h100 + k, k[0]);
      for (int k = 0; k < 12; k++) rd(k[3:0], !k[0], 32'h100 + k, 0);
      rd(4'hC, 1'b1, 32'h0, 1'b1);
      wr_ch(4'h0, 32'h3, 1'b1);
      tick(2, 1'b0);
      rd(4'h0, 1'b1, 32'h1, 1'b0);
      chk(timeout_irq, 12'h000);
      tick(1, 1'b0);
      chk(timeout_irq, 12'h001);
      rd(4'h0, 1'b1, 32'h0, 1'b0);
      tick(2, 1'b0);
      chk(timeout_irq, 12'h001);
      wr_ch(4'h0, 32'h5, 1'b1);
      chk(timeout_irq, 12'h000);
      wr_ch(4'h0, 32'h0, 1'b1);
      clk(1);
      chk(timeout_irq, 12'h001);
      $display("test channels done");
      perm(aotst_pkg::PSEL_WMASK, 32'h0, 1'b0);
      chk(nonsecure_write_perm_mask, 32'hFFFF_FFF0);
      perm(aotst_pkg::PSEL_LOCK, 32'h1, 1'b0);
      chk(perm_mask_lock, 1'b0);
      perm(aotst_pkg::PSEL_WMASK, 32'hFFFF_FFF1, 1'b1);
      ctl(aotst_pkg::DIV_13M, 1'b0);
      chk(div_sel, aotst_pkg::DIV_13M);
      perm(aotst_pkg::PSEL_RMASK, 32'hFFFF_FFEF, 1'b1);
      rd(4'h0, 1'b0, 32'h0, 1'b1);
      perm(aotst_pkg::PSEL_LOCK, 32'h1, 1'b1);
      perm(aotst_pkg::PSEL_WMASK, 32'h0, 1'b1);
      chk(nonsecure_write_perm_mask, 32'hFFFF_FFF1);
      perm(aotst_pkg::PSEL_RMASK, 32'hFFFF_FFFF, 1'b1);
      chk(nonsecure_read_perm_mask, 32'hFFFF_FFEF);
      perm(aotst_pkg::PSEL_LOCK, 32'h0, 1'b1);
      chk(perm_mask_lock, 1'b1);
      @(posedge sys_clk);
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      clk(0);
      chk(perm_mask_lock, 1'b0);
      $display("test permissions done");
      tally_and_finish();
   end
endmodule
